// ### design/hbp_buffer_port.sv
// Purpose: Processor access to list buffer RAM and read-back length registers
// Assumes: Bus strobes come from logic on core_clk; one strobe per cycle at most
// Notes: Read answers leave through a two-entry buffer with valid/ready
//
// Overview of operation
// RQ1: Command 2D returns the pending byte count of isochronous buffer A.
// RQ2: Command 2E returns the pending byte count of isochronous buffer B.
// RQ3: Processor loads the transfer counter with buffer A count before reading it back.
// RQ4: Processor loads the transfer counter with buffer B count before reading it back.
// RQ5: Isochronous port word holds even byte in 15:8, odd byte in 7:0.
// RQ6: Acknowledged port word holds even byte in 15:8, odd byte in 7:0.
// RQ7: Commands 40 and C0 open the isochronous port for read and write.
// RQ8: Commands 41 and C1 open the acknowledged port for read and write.
// RQ9: Processor programs the transfer counter and checks status before port access.
// RQ10: Processor issues the port command once, then moves the block word by word.
// RQ11: Each port word advances the byte pointer by two until it meets the count.
// RQ12: Reaching the count raises end of transfer and updates buffer status.
// RQ13: Processor gives the transfer counter in bytes, not words.
// RQ14: Status keeps a done flag and a full flag for each buffer.
// RQ15: Processor keeps the sum of all buffer lengths within 4 kbytes.
// RQ16: Reading a read-back length register changes no pointer, data or flag.
`timescale 1ns/100ps
`default_nettype none
module hbp_buffer_port
    import hbp_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_a0,
    input wire logic [hbp_pkg::DATA_W-1:0] bus_wdata,
    output logic bus_rd_accept,
    output logic [hbp_pkg::DATA_W-1:0] port_word,
    output logic port_word_valid,
    input wire logic port_word_ready,
    input wire logic [hbp_pkg::DATA_W-1:0] transfer_byte_counter,
    input wire logic [hbp_pkg::DATA_W-1:0] iso_a_pending_bytes,
    input wire logic [hbp_pkg::DATA_W-1:0] iso_b_pending_bytes,
    input wire logic [hbp_pkg::DATA_W-1:0] iso_buffer_length,
    input wire logic iso_cpu_sel_b,
    input wire logic [hbp_pkg::FLAG_W/2-1:0] engine_read_done,
    input wire logic [hbp_pkg::FLAG_W/2-1:0] engine_emptied,
    output logic end_of_transfer,
    output logic [hbp_pkg::FLAG_W-1:0] buffer_state_flags
);
    import hbp_pkg::*;

    hbp_state_type state_reg;
    logic [DATA_W-1:0] ptr_reg;
    logic [7:0] ram [0:RAM_BYTES-1];
    logic [DATA_W-1:0] head_reg;
    logic [DATA_W-1:0] tail_reg;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic xfer_end_reg;
    logic [FLAG_W-1:0] flags_reg;
    logic [FLAG_W-1:0] flags_next;
    logic accept_reg;
    logic cmd_strobe;
    logic data_wr;
    logic data_rd;
    logic port_open;
    logic port_live;
    logic is_ack;
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] addr;
    logic push;
    logic pop;
    logic [DATA_W-1:0] push_word;
    logic step;
    logic [DATA_W-1:0] ptr_plus;
    logic last_word;

    // Byte address inside the shared RAM; wraps at 4 kbytes
    function automatic logic [ADDR_W-1:0] ram_addr(input logic [ADDR_W-1:0] b,
                                                   input logic [DATA_W-1:0] p);
        ram_addr = b + p[ADDR_W-1:0];
    endfunction : ram_addr

    assign cmd_strobe = bus_wr && bus_a0;
    assign data_wr = bus_wr && !bus_a0;
    assign data_rd = bus_rd && !bus_a0 && accept_reg;
    assign is_ack = (state_reg == ST_ACK_RD) || (state_reg == ST_ACK_WR);
    assign port_open = (state_reg == ST_ISO_RD) || (state_reg == ST_ISO_WR) || is_ack;
    // Past the count the port goes quiet, so a stray access cannot spill
    assign port_live = port_open && (ptr_reg < transfer_byte_counter);
    assign base = is_ack ? ADDR_W'(iso_buffer_length << 1) :
                  (iso_cpu_sel_b ? iso_buffer_length[ADDR_W-1:0] : {ADDR_W{1'b0}});
    assign addr = ram_addr(base, ptr_reg);
    assign ptr_plus = ptr_reg + PTR_STEP;
    // Odd counts end on the word that holds the last byte
    assign last_word = ptr_plus >= transfer_byte_counter;

    always_comb
    begin
        push = 1'b0;
        push_word = WORD_RESET;
        step = 1'b0;
        if (data_rd)
        begin
            case (state_reg)
                // RQ16: length reads never step
                // RQ1: buffer A length
                ST_LEN_A:
                begin
                    push = 1'b1;
                    push_word = iso_a_pending_bytes;
                end
                // RQ2: buffer B length
                ST_LEN_B:
                begin
                    push = 1'b1;
                    push_word = iso_b_pending_bytes;
                end
                // RQ5: even byte high
                ST_ISO_RD, ST_ACK_RD:
                begin
                    push = port_live;
                    push_word = {ram[addr], ram[ram_addr(addr + BYTE_NEXT, WORD_RESET)]};
                    step = port_live;
                end
                default:
                begin
                    push = 1'b1;
                    push_word = WORD_RESET;
                end
            endcase
        end
        else if (data_wr && port_live && (state_reg == ST_ISO_WR || state_reg == ST_ACK_WR))
        begin
            step = 1'b1;
        end
    end

    // RQ7: iso port open commands
    // RQ8: ack port open commands
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_reg <= ST_IDLE;
        end
        else if (cmd_strobe)
        begin
            case (bus_wdata[CMD_W-1:0])
                CMD_RD_ISO_A_LEN: state_reg <= ST_LEN_A;
                CMD_RD_ISO_B_LEN: state_reg <= ST_LEN_B;
                CMD_RD_ISO_PORT: state_reg <= ST_ISO_RD;
                CMD_WR_ISO_PORT: state_reg <= ST_ISO_WR;
                CMD_RD_ACK_PORT: state_reg <= ST_ACK_RD;
                CMD_WR_ACK_PORT: state_reg <= ST_ACK_WR;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // RQ11: pointer steps by two
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ptr_reg <= WORD_RESET;
        end
        else if (cmd_strobe)
        begin
            ptr_reg <= WORD_RESET;
        end
        else if (step)
        begin
            ptr_reg <= last_word ? transfer_byte_counter : ptr_plus;
        end
    end

    // RQ6: even byte high on writes
    always_ff @(posedge core_clk)
    begin
        if (step && data_wr)
        begin
            ram[addr] <= bus_wdata[15:8];
            ram[ram_addr(addr + BYTE_NEXT, WORD_RESET)] <= bus_wdata[7:0];
        end
    end

    // RQ12: end of transfer pulse
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            xfer_end_reg <= 1'b0;
        end
        else
        begin
            xfer_end_reg <= step && last_word;
        end
    end

    // RQ14: done and full flags; hardware set wins over clear
    always_comb
    begin
        flags_next = flags_reg;
        flags_next[FULL_ISO_A] = flags_reg[FULL_ISO_A] && !engine_emptied[0];
        flags_next[FULL_ISO_B] = flags_reg[FULL_ISO_B] && !engine_emptied[1];
        flags_next[FULL_ACK] = flags_reg[FULL_ACK] && !engine_emptied[2];
        flags_next[DONE_ISO_A] = flags_reg[DONE_ISO_A] || engine_read_done[0];
        flags_next[DONE_ISO_B] = flags_reg[DONE_ISO_B] || engine_read_done[1];
        flags_next[DONE_ACK] = flags_reg[DONE_ACK] || engine_read_done[2];
        // RQ12: status update at end
        if (step && last_word)
        begin
            case (state_reg)
                ST_ISO_WR:
                begin
                    flags_next[iso_cpu_sel_b ? FULL_ISO_B : FULL_ISO_A] = 1'b1;
                    flags_next[iso_cpu_sel_b ? DONE_ISO_B : DONE_ISO_A] = 1'b0;
                end
                ST_ACK_WR:
                begin
                    flags_next[FULL_ACK] = 1'b1;
                    flags_next[DONE_ACK] = 1'b0;
                end
                // Read-back drains the buffer for the engine's next fill
                ST_ISO_RD:
                begin
                    flags_next[iso_cpu_sel_b ? DONE_ISO_B : DONE_ISO_A] = 1'b0;
                end
                ST_ACK_RD:
                begin
                    flags_next[DONE_ACK] = 1'b0;
                end
                default:
                begin
                    flags_next = flags_next;
                end
            endcase
        end
        // Engine set wins over a same-cycle clear
        flags_next[DONE_ISO_A] = flags_next[DONE_ISO_A] || engine_read_done[0];
        flags_next[DONE_ISO_B] = flags_next[DONE_ISO_B] || engine_read_done[1];
        flags_next[DONE_ACK] = flags_next[DONE_ACK] || engine_read_done[2];
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            flags_reg <= FLAGS_RESET;
        end
        else
        begin
            flags_reg <= flags_next;
        end
    end

    // Two-entry answer buffer; head is the visible word
    assign pop = port_word_valid && port_word_ready;
    assign cnt_next = cnt_reg + 2'(push) - 2'(pop);

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            cnt_reg <= 2'b00;
            head_reg <= WORD_RESET;
            tail_reg <= WORD_RESET;
            port_word_valid <= 1'b0;
            accept_reg <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_next;
            port_word_valid <= cnt_next != 2'b00;
            // Full buffer refuses reads, so a stalled receiver loses nothing
            accept_reg <= cnt_next < 2'(FIFO_DEPTH);
            if (push && (cnt_reg == 2'b00 || (cnt_reg == 2'b01 && pop)))
            begin
                head_reg <= push_word;
            end
            else if (pop && cnt_reg == 2'(FIFO_DEPTH))
            begin
                head_reg <= tail_reg;
            end
            if (push && (cnt_reg == 2'(FIFO_DEPTH) || (cnt_reg == 2'b01 && !pop)))
            begin
                tail_reg <= push_word;
            end
        end
    end

    assign bus_rd_accept = accept_reg;
    assign port_word = head_reg;
    assign end_of_transfer = xfer_end_reg;
    assign buffer_state_flags = flags_reg;
endmodule : hbp_buffer_port
`default_nettype wire

// ### include/hbp_pkg.sv
// Purpose: Shared constants for the host buffer RAM port
// Assumes: 16-bit processor data bus, byte-organised 4 kbyte buffer RAM
// Notes: Command codes arrive on the low byte during a command phase
package hbp_pkg;
    localparam int DATA_W = 16;
    localparam int CMD_W = 8;
    localparam int ADDR_W = 12;
    localparam int RAM_BYTES = 4096;
    localparam int FIFO_DEPTH = 2;
    localparam logic [CMD_W-1:0] CMD_RD_ISO_A_LEN = 8'h2D;
    localparam logic [CMD_W-1:0] CMD_RD_ISO_B_LEN = 8'h2E;
    localparam logic [CMD_W-1:0] CMD_RD_ISO_PORT = 8'h40;
    localparam logic [CMD_W-1:0] CMD_WR_ISO_PORT = 8'hC0;
    localparam logic [CMD_W-1:0] CMD_RD_ACK_PORT = 8'h41;
    localparam logic [CMD_W-1:0] CMD_WR_ACK_PORT = 8'hC1;
    localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] PTR_STEP = 16'h0002;
    localparam logic [ADDR_W-1:0] BYTE_NEXT = 12'h001;
    // Flag layout of buffer_state_flags
    localparam int FLAG_W = 6;
    localparam int FULL_ISO_A = 0;
    localparam int FULL_ISO_B = 1;
    localparam int FULL_ACK = 2;
    localparam int DONE_ISO_A = 3;
    localparam int DONE_ISO_B = 4;
    localparam int DONE_ACK = 5;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 6'h00;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LEN_A = 3'b001,
        ST_LEN_B = 3'b011,
        ST_ISO_RD = 3'b010,
        ST_ISO_WR = 3'b110,
        ST_ACK_RD = 3'b111,
        ST_ACK_WR = 3'b101
    } hbp_state_type;
endpackage : hbp_pkg

// ### sim/hbp_buffer_port_properties.sv
// Purpose: Port assertions for hbp_buffer_port
// Assumes: One clock, synchronous active-low reset
// Notes: Tracks the last command code itself
`timescale 1ns/100ps
`default_nettype none
module hbp_buffer_port_properties
    import hbp_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_a0,
    input wire logic [hbp_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_rd_accept,
    input wire logic [hbp_pkg::DATA_W-1:0] port_word,
    input wire logic port_word_valid,
    input wire logic port_word_ready,
    input wire logic [hbp_pkg::DATA_W-1:0] iso_a_pending_bytes,
    input wire logic [hbp_pkg::FLAG_W/2-1:0] engine_read_done,
    input wire logic end_of_transfer,
    input wire logic [hbp_pkg::FLAG_W-1:0] buffer_state_flags
);
    logic [CMD_W-1:0] cmd_reg;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge core_clk)
        if (!resetn)
            cmd_reg <= 8'h00;
        else if (bus_wr && bus_a0)
            cmd_reg <= bus_wdata[CMD_W-1:0];
    sequence s_len_rd(code);
        cmd_reg == code && bus_rd && bus_rd_accept && !bus_a0;
    endsequence
    a_len_a_word: assert property (s_len_rd(CMD_RD_ISO_A_LEN) ##0 !port_word_valid
        |=> port_word_valid && port_word == $past(iso_a_pending_bytes))
        else $error("Bad length word");
    a_len_quiet: assert property ((s_len_rd(CMD_RD_ISO_A_LEN) or s_len_rd(CMD_RD_ISO_B_LEN))
        |=> !end_of_transfer) else $error("Length read ended a transfer");
    a_word_holds: assert property (port_word_valid && !port_word_ready
        |=> port_word_valid && $stable(port_word)) else $error("Word lost in stall");
    a_end_single: assert property (end_of_transfer |=> !end_of_transfer)
        else $error("End pulse too long");
    a_end_cause: assert property (end_of_transfer
        |-> $past(!bus_a0 && (bus_wr || (bus_rd && bus_rd_accept)))) else $error("Stray end");
    a_ack_full: assert property (end_of_transfer && $past(cmd_reg) == CMD_WR_ACK_PORT
        |-> buffer_state_flags[FULL_ACK]) else $error("Ack full flag not set");
    a_done_set: assert property (engine_read_done[0] |=> buffer_state_flags[DONE_ISO_A])
        else $error("Done flag not set");
    a_room_free: assert property (!bus_rd_accept |-> port_word_valid)
        else $error("Refusing with empty buffer");
endmodule : hbp_buffer_port_properties
bind hbp_buffer_port hbp_buffer_port_properties u_props (.core_clk, .resetn, .bus_wr, .bus_rd,
    .bus_a0, .bus_wdata, .bus_rd_accept, .port_word, .port_word_valid, .port_word_ready,
    .iso_a_pending_bytes, .engine_read_done, .end_of_transfer, .buffer_state_flags);
`default_nettype wire

// ### sim/hbp_host_model.sv
// Purpose: Processor model on the command/data bus
// Assumes: Requests launched 1 ns after a rising edge
// Notes: Released data bus shows inverted value
`timescale 1ns/100ps
`default_nettype none
module hbp_host_model
    import hbp_pkg::*;
(
    input wire logic core_clk,
    output logic bus_wr,
    output logic bus_rd,
    output logic bus_a0,
    output logic [hbp_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_rd_accept,
    input wire logic [hbp_pkg::DATA_W-1:0] port_word,
    input wire logic port_word_valid,
    output logic port_word_ready
);
    logic hung = 1'b0;
    int slow = 0;
    initial {bus_wr, bus_rd, bus_a0, port_word_ready, bus_wdata} = '0;
    task automatic put(input logic a0, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        #1 {bus_wr, bus_a0, bus_wdata} = {1'b1, a0, d};
        @(posedge core_clk);
        #1 {bus_wr, bus_wdata} = {1'b0, ~d};
    endtask : put
    // Read held until accept seen
    task automatic ask();
        int n = 0;
        @(posedge core_clk);
        #1 {bus_rd, bus_a0} = 2'b10;
        do @(posedge core_clk); while (bus_rd_accept !== 1'b1 && ++n < 50);
        #1 bus_rd = 1'b0;
        hung = hung | (n >= 50);
    endtask : ask
    task automatic take(output logic [DATA_W-1:0] w);
        int n = 0;
        repeat (slow) @(posedge core_clk);
        #1 port_word_ready = 1'b1;
        do @(posedge core_clk); while (port_word_valid !== 1'b1 && ++n < 50);
        w = port_word;
        #1 port_word_ready = 1'b0;
        hung = hung | (n >= 50);
    endtask : take
endmodule : hbp_host_model
`default_nettype wire

// ### sim/host_buffer_ram_port_test.sv
// Purpose: Self-checking bench for hbp_buffer_port
// Assumes: Host model drives the bus
// Notes: Overlapping buffer bases expose byte order
`timescale 1ns/100ps
`default_nettype none
module host_buffer_ram_port_test;
    import hbp_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic bus_wr, bus_rd, bus_a0, bus_rd_accept, port_word_valid, port_word_ready;
    logic end_of_transfer, iso_cpu_sel_b = 1'b0;
    logic [DATA_W-1:0] bus_wdata, port_word, w, wd [4], transfer_byte_counter = '0;
    logic [DATA_W-1:0] iso_a_pending_bytes = '0, iso_b_pending_bytes = '0;
    logic [DATA_W-1:0] iso_buffer_length = 16'h0001;
    logic [2:0] engine_read_done = 3'h0, engine_emptied = 3'h0;
    logic [FLAG_W-1:0] buffer_state_flags;
    int miscompares = 0, checks_done = 0, ends_seen = 0;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (end_of_transfer === 1'b1) ends_seen++;
    always @(posedge cpu.hung) report_and_stop();
    hbp_buffer_port DUT (.core_clk, .resetn, .bus_wr, .bus_rd, .bus_a0, .bus_wdata,
        .bus_rd_accept, .port_word, .port_word_valid, .port_word_ready,
        .transfer_byte_counter, .iso_a_pending_bytes, .iso_b_pending_bytes,
        .iso_buffer_length, .iso_cpu_sel_b, .engine_read_done, .engine_emptied,
        .end_of_transfer, .buffer_state_flags);
    hbp_host_model cpu (.core_clk, .bus_wr, .bus_rd, .bus_a0, .bus_wdata,
        .bus_rd_accept, .port_word, .port_word_valid, .port_word_ready);
    function automatic logic [DATA_W-1:0] join_bytes(logic [7:0] even_b, logic [7:0] odd_b);
        return {even_b, odd_b};
    endfunction : join_bytes
    task automatic chk(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
        checks_done++;
        if (got !== exp) miscompares++;
        if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    endtask : chk
    task automatic rd_chk(string what, logic [DATA_W-1:0] exp);
        cpu.ask();
        cpu.take(w);
        chk(what, exp, w);
    endtask : rd_chk
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask : settle
    task automatic report_and_stop();
        miscompares += cpu.hung;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        void'($urandom(11324));
        repeat (3) @(posedge core_clk);
        #1 resetn = 1'b1;
        chk("reset flags", 16'h0000, 16'(buffer_state_flags));
        iso_a_pending_bytes = 16'($urandom);
        iso_b_pending_bytes = 16'($urandom);
        cpu.put(1'b1, 16'(CMD_RD_ISO_A_LEN));
        rd_chk("len a", iso_a_pending_bytes);
        cpu.put(1'b1, 16'(CMD_RD_ISO_B_LEN));
        rd_chk("len b", iso_b_pending_bytes);
        rd_chk("len b again", iso_b_pending_bytes);
        cpu.put(1'b1, 16'h00AA);
        rd_chk("idle read", 16'h0000);
        chk("end after len", 16'h0000, 16'(ends_seen));
        $display("test lengths done");
        transfer_byte_counter = 16'h0008;
        cpu.put(1'b1, 16'(CMD_WR_ISO_PORT));
        foreach (wd[i])
        begin
            wd[i] = 16'($urandom);
            cpu.put(1'b0, wd[i]);
        end
        settle();
        chk("end write", 16'h0001, 16'(ends_seen));
        chk("full a", 16'h0001, 16'(buffer_state_flags[FULL_ISO_A]));
        cpu.put(1'b1, 16'(CMD_RD_ISO_PORT));
        foreach (wd[i]) rd_chk("iso word", wd[i]);
        cpu.ask();
        settle();
        chk("read past count", 16'h0000, 16'(port_word_valid));
        // buffer B seen at base one
        iso_cpu_sel_b = 1'b1;
        transfer_byte_counter = 16'h0002;
        cpu.put(1'b1, 16'(CMD_RD_ISO_PORT));
        rd_chk("iso b word", join_bytes(wd[0][7:0], wd[1][15:8]));
        iso_cpu_sel_b = 1'b0;
        cpu.put(1'b1, 16'(CMD_RD_ACK_PORT));
        rd_chk("ack word", wd[1]);
        transfer_byte_counter = 16'h0006;
        cpu.put(1'b1, 16'(CMD_RD_ACK_PORT));
        rd_chk("ack partial", wd[1]);
        settle();
        chk("end count", 16'h0004, 16'(ends_seen));
        $display("test buffers done");
        transfer_byte_counter = 16'h0008;
        cpu.put(1'b1, 16'(CMD_RD_ISO_PORT));
        cpu.ask();
        cpu.ask();
        settle();
        chk("buffer full", 16'h0000, 16'(bus_rd_accept));
        cpu.slow = 3;
        foreach (wd[i])
        begin
            if (i > 1) cpu.ask();
            cpu.take(w);
            chk("stalled word", wd[i], w);
        end
        engine_read_done = 3'h7;
        @(posedge core_clk);
        #1 engine_read_done = 3'h0;
        engine_emptied = 3'h7;
        @(posedge core_clk);
        #1 engine_emptied = 3'h0;
        settle();
        chk("engine flags", 16'h0038, 16'(buffer_state_flags));
        transfer_byte_counter = 16'h0002;
        cpu.put(1'b1, 16'(CMD_WR_ACK_PORT));
        cpu.put(1'b0, 16'($urandom));
        settle();
        chk("full ack", 16'h0001, 16'(buffer_state_flags[FULL_ACK]));
        $display("test stall and flags done");
        report_and_stop();
    end
endmodule : host_buffer_ram_port_test
`default_nettype wire
